// file: design/framer_pkg.sv
/*
  constants, carrier structs and state layout of the telemetry record
  framer. assumes one clock (hclk, 25 MHz) and an ahb-lite register bus.
*/
package framer_pkg;

  localparam logic [31:0] SYNC_WORD   = 32'h3003_0330;
  localparam logic [7:0]  MODULE_BIAS = 8'h01;
  localparam logic [15:0] HDR_BYTES   = 16'h0008;
  localparam logic [15:0] TS_BYTES    = 16'h0006;
  localparam logic [15:0] ST_BYTES    = 16'h0030;
  localparam int          ST_WORDS    = 12;
  localparam int          ST_AW       = 4;

  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_WORDS  = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_STBLK  = 8'h40;
  localparam logic [7:0] OFS_STEND  = 8'h6c;

  localparam int CTRL_EN    = 0;
  localparam int CTRL_TS    = 1;
  localparam int CTRL_ST    = 2;
  localparam int CTRL_WIDE  = 3;
  localparam int CTRL_SRC_L = 8;
  localparam logic [31:0] CTRL_MASK = 32'h0000_ff0f;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'h0,
    FSM_HDR  = 3'h1,
    FSM_TS   = 3'h3,
    FSM_STAT = 3'h2,
    FSM_DATA = 3'h6
  } fsm_t;

  typedef struct packed {
    logic        sof;
    logic [15:0] word;
  } pcm_word_t;

  typedef struct packed {
    logic       first;
    logic       last;
    logic [7:0] data;
  } rec_byte_t;

  typedef struct packed {
    logic [10:0] day;
    logic [26:0] msec;
    logic [9:0]  usec;
  } day_time_stamp_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] words;
    logic [15:0] rec_count;
    logic        pend;
    logic        pend_wr;
    logic [7:0]  pend_ofs;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    fsm_t        fsm;
    logic [15:0] cnt;
    logic        phase;
    logic        c_ts;
    logic        c_st;
    logic        c_wide;
    logic [7:0]  c_src;
    logic [15:0] c_words;
    logic [15:0] offset;
    logic [47:0] ts;
    pcm_word_t   hold;
    logic        hold_full;
    logic        pcm_ready;
    logic        out_valid;
    rec_byte_t   out;
  } state_t;

endpackage

// file: design/status_block_mem.sv
/*
  small word memory holding the appended status block.
  assumes writes come from the register bus; read data registered.
*/
`timescale 1ns/1ps
module status_block_mem
  import framer_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             we,
  input  wire logic [ST_AW-1:0] waddr,
  input  wire logic [31:0]      wdata,
  input  wire logic [ST_AW-1:0] raddr,
  output logic      [31:0]      rdata
);

  logic [31:0] mem [ST_WORDS];

  always_ff @(posedge hclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// file: design/telemetry_frame_record_framer.sv
/*
  record framer: wraps each pcm minor frame in a multiplex header with
  optional time stamp and status block, as a byte stream.
  assumes pcm words, time and the byte sink share hclk; ahb-lite slave.
*/
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
module telemetry_frame_record_framer
  import framer_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire logic            hsel,
  input  wire logic [31:0]     haddr,
  input  wire logic [1:0]      htrans,
  input  wire logic            hwrite,
  input  wire logic [2:0]      hsize,
  input  wire logic [31:0]     hwdata,
  input  wire logic            hready,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic      [31:0]     hrdata,
  input  wire day_time_stamp_t day_time_stamp,
  input  wire logic            pcm_valid,
  input  wire pcm_word_t       pcm_in,
  output logic                 pcm_ready,
  output logic                 out_valid,
  output rec_byte_t            out_byte,
  input  wire logic            out_ready
);

  localparam state_t ST_RESET = '{hreadyout: 1'b1, fsm: FSM_IDLE,
                                  default: '0};

  state_t            s;
  state_t            next_s;
  logic              mem_we;
  logic [ST_AW-1:0]  mem_waddr;
  logic [ST_AW-1:0]  mem_raddr;
  logic [31:0]       mem_rdata;

  status_block_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (mem_we),
    .waddr   (mem_waddr),
    .wdata   (hwdata),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  logic        can_load;
  logic        emit;
  logic [7:0]  byte_val;
  logic        byte_last;
  logic [15:0] data_len;
  logic [15:0] ofs_sum;
  logic [7:0]  blk_ofs;

  always_comb begin
    next_s    = s;
    mem_we    = 1'b0;
    mem_waddr = '0;
    emit      = 1'b0;
    byte_val  = 8'h00;
    byte_last = 1'b0;
    blk_ofs   = s.pend_ofs - OFS_STBLK;
    can_load  = !s.out_valid || out_ready;
    data_len  = s.ctrl[CTRL_WIDE] ? {s.words[14:0], 1'b0} : s.words;
    ofs_sum   = data_len;
    if (s.ctrl[CTRL_TS]) begin
      ofs_sum = ofs_sum + TS_BYTES;
    end
    if (s.ctrl[CTRL_ST]) begin
      ofs_sum = ofs_sum + ST_BYTES;
    end

    // register bus: one wait state, then answer
    next_s.hresp = 1'b0;
    if (s.pend) begin
      next_s.pend      = 1'b0;
      next_s.hreadyout = 1'b1;
      next_s.hrdata    = 32'h0000_0000;
      if (s.pend_wr) begin
        case (s.pend_ofs)
          OFS_CTRL:  next_s.ctrl  = hwdata & CTRL_MASK;
          OFS_WORDS: next_s.words = hwdata[15:0];
          default: begin
            if (s.pend_ofs >= OFS_STBLK && s.pend_ofs <= OFS_STEND) begin
              mem_we    = 1'b1;
              mem_waddr = blk_ofs[ST_AW+1:2];
            end
          end
        endcase
      end else begin
        case (s.pend_ofs)
          OFS_CTRL:   next_s.hrdata = s.ctrl;
          OFS_WORDS:  next_s.hrdata = {16'h0000, s.words};
          OFS_STATUS: next_s.hrdata = {s.rec_count, 15'h0000,
                                       s.fsm != FSM_IDLE};
          default:    next_s.hrdata = 32'h0000_0000;
        endcase
      end
    end else if (hsel && htrans[1] && hready) begin
      next_s.pend      = 1'b1;
      next_s.pend_wr   = hwrite;
      next_s.hreadyout = 1'b0;
      next_s.pend_ofs  = (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
    end

    // one-word input holding register
    if (pcm_valid && s.pcm_ready) begin
      next_s.hold      = pcm_in;
      next_s.hold_full = 1'b1;
    end

    case (s.fsm)
      FSM_IDLE: begin
        if (s.hold_full && !s.hold.sof) begin
          next_s.hold_full = 1'b0;
        end else if (s.hold_full && s.ctrl[CTRL_EN] &&
                     s.words != 16'h0000) begin
          next_s.fsm     = FSM_HDR;
          next_s.cnt     = '0;
          next_s.phase   = 1'b0;
          next_s.c_ts    = s.ctrl[CTRL_TS];
          next_s.c_st    = s.ctrl[CTRL_ST];
          next_s.c_wide  = s.ctrl[CTRL_WIDE];
          next_s.c_src   = s.ctrl[CTRL_SRC_L +: 8] - MODULE_BIAS;
          next_s.c_words = s.words;
          next_s.offset  = ofs_sum;
          next_s.ts      = {2'b00, day_time_stamp.day[8:0],
                            day_time_stamp.msec,
                            day_time_stamp.usec};
        end
      end
      FSM_HDR: begin
        if (can_load) begin
          emit = 1'b1;
          case (s.cnt[2:0])
            3'h0: byte_val = SYNC_WORD[31:24];
            3'h1: byte_val = SYNC_WORD[23:16];
            3'h2: byte_val = SYNC_WORD[15:8];
            3'h3: byte_val = SYNC_WORD[7:0];
            3'h4: byte_val = s.c_src;
            3'h5: byte_val = {6'h00, s.c_st, s.c_ts};
            3'h6: byte_val = s.offset[7:0];
            default: byte_val = s.offset[15:8];
          endcase
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt == HDR_BYTES - 16'h0001) begin
            next_s.cnt = '0;
            if (s.c_ts) begin
              next_s.fsm = FSM_TS;
            end else if (s.c_st) begin
              next_s.fsm = FSM_STAT;
            end else begin
              next_s.fsm = FSM_DATA;
            end
          end
        end
      end
      FSM_TS: begin
        if (can_load) begin
          emit       = 1'b1;
          byte_val   = s.ts[6'd47 - {s.cnt[2:0], 3'b000} -: 8];
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt == TS_BYTES - 16'h0001) begin
            next_s.cnt = '0;
            next_s.fsm = s.c_st ? FSM_STAT : FSM_DATA;
          end
        end
      end
      FSM_STAT: begin
        if (can_load) begin
          emit       = 1'b1;
          byte_val   = mem_rdata[{s.cnt[1:0], 3'b000} +: 8];
          next_s.cnt = s.cnt + 16'h0001;
          if (s.cnt == ST_BYTES - 16'h0001) begin
            next_s.cnt = '0;
            next_s.fsm = FSM_DATA;
          end
        end
      end
      FSM_DATA: begin
        if (can_load && s.hold_full) begin
          emit = 1'b1;
          if (s.c_wide && !s.phase) begin
            byte_val     = s.hold.word[15:8];
            next_s.phase = 1'b1;
          end else begin
            byte_val         = s.hold.word[7:0];
            next_s.phase     = 1'b0;
            next_s.hold_full = 1'b0;
            next_s.cnt       = s.cnt + 16'h0001;
            if (s.cnt == s.c_words - 16'h0001) begin
              byte_last        = 1'b1;
              next_s.fsm       = FSM_IDLE;
              next_s.rec_count = s.rec_count + 16'h0001;
            end
          end
        end
      end
      default: next_s.fsm = FSM_IDLE;
    endcase

    // a new word may only be taken once the held one is gone
    if (pcm_valid && s.pcm_ready) begin
      next_s.hold_full = 1'b1;
    end

    if (emit) begin
      next_s.out_valid  = 1'b1;
      next_s.out.data   = byte_val;
      next_s.out.first  = (s.fsm == FSM_HDR) && (s.cnt == 16'h0000);
      next_s.out.last   = byte_last;
    end else if (out_ready) begin
      next_s.out_valid  = 1'b0;
    end
    next_s.pcm_ready = !next_s.hold_full;
    mem_raddr        = next_s.cnt[ST_AW+1:2];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign hreadyout = s.hreadyout;
  assign hresp     = s.hresp;
  assign hrdata    = s.hrdata;
  assign pcm_ready = s.pcm_ready;
  assign out_valid = s.out_valid;
  assign out_byte  = s.out;

endmodule

// file: bench/framer_asserts.sv
/* checker for the framer ports: bus wait, pcm take, byte hold, layout.
   assumes it is bound onto the framer top. */
`timescale 1ns/1ps
module framer_asserts
  import framer_pkg::*;
(
  input wire logic [1:0] htrans,
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       pcm_valid,
  input wire logic       pcm_ready,
  input wire logic       out_valid,
  input wire rec_byte_t  out_byte,
  input wire logic       out_ready
);
  logic [15:0] idx;
  logic [15:0] off;
  logic [7:0]  typ;
  wire         mid = out_valid && !out_byte.first;
  // index of the offered byte, plus the type and offset taken so far
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      idx <= 16'h0;
      off <= 16'h0;
      typ <= 8'h0;
    end else if (out_valid && out_ready) begin
      idx <= out_byte.first ? 16'h1 : idx + 16'h1;
      if (idx == 16'h5) typ <= out_byte.data;
      if (idx == 16'h6) off[7:0] <= out_byte.data;
      if (idx == 16'h7) off[15:8] <= out_byte.data;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sync_open_a: assert property (
    out_valid && out_byte.first |-> out_byte.data == 8'h30) else $error("open");
  sync_mid_a: assert property (
    mid && idx inside {1, 2} |-> out_byte.data == 8'h03) else $error("sync");
  type_code_a: assert property (
    mid && idx == 16'h5 |-> out_byte.data[7:2] == 6'h0) else $error("type");
  day_pad_a: assert property (
    mid && idx == 16'h8 && typ[0] |-> out_byte.data[7:6] == 2'h0)
    else $error("day pad");
  rec_len_a: assert property (
    mid && out_byte.last |-> idx == off + 16'h7) else $error("offset");
  byte_hold_a: assert property (
    out_valid && !out_ready |=> out_valid && $stable(out_byte))
    else $error("byte dropped");
  pcm_take_a: assert property (
    pcm_valid && pcm_ready |=> !pcm_ready) else $error("pcm ready");
  bus_wait_a: assert property (
    hsel && htrans[1] && hready |=> !hreadyout ##1 hreadyout)
    else $error("wait state");
endmodule
bind telemetry_frame_record_framer framer_asserts chk (.hclk, .hresetn,
  .hsel, .htrans, .hready, .hreadyout, .pcm_valid, .pcm_ready,
  .out_valid, .out_byte, .out_ready);

// file: bench/rec_sink.sv
/* recorder model taking the record bytes, stalling when slow.
   assumes the framer byte port on hclk. */
`timescale 1ns/1ps
module rec_sink
  import framer_pkg::*;
(
  input  wire logic      hclk,
  input  wire logic      hresetn,
  input  wire logic      slow,
  input  wire logic      out_valid,
  input  wire rec_byte_t out_byte,
  output logic           out_ready
);
  rec_byte_t  q[$];
  logic [1:0] n;
  // half rate acceptance when slow
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      n <= n + 2'h1;
      out_ready <= !slow || n[1];
      if (out_valid && out_ready) q.push_back(out_byte);
    end
  end
endmodule

// file: bench/telemetry_frame_record_framer_tb.sv
/* bench for the record framer: four layouts from a row table, then
   register checks. assumes rec_sink as the recorder. */
`timescale 1ns/1ps
module telemetry_frame_record_framer_tb
  import framer_pkg::*;
();
  typedef struct {
    logic [31:0] ctrl;
    logic [15:0] words;
    logic [7:0]  typ;
    logic [7:0]  src;
    logic [15:0] off;
  } row_t;
  row_t            rows [4] = '{'{32'h0301, 16'h4, 8'h0, 8'h02, 16'h04},
    '{32'h0103, 16'h3, 8'h1, 8'h00, 16'h09},
    '{32'h080d, 16'h2, 8'h2, 8'h07, 16'h34},
    '{32'h000f, 16'h5, 8'h3, 8'hff, 16'h40}};
  logic            hclk = 1'b0;
  logic            hresetn;
  logic            hsel;
  logic [31:0]     haddr;
  logic [1:0]      htrans;
  logic            hwrite;
  logic [31:0]     hwdata;
  logic            hreadyout;
  logic            hresp;
  logic [31:0]     hrdata;
  day_time_stamp_t dts;
  logic            pcm_valid;
  pcm_word_t       pcm_in;
  logic            pcm_ready;
  logic            out_valid;
  rec_byte_t       out_byte;
  logic            out_ready;
  logic            slow;
  int              failures;
  int              checks_done;
  logic [7:0]      e[$];
  logic [31:0]     v;
  logic [47:0]     stamp;

  telemetry_frame_record_framer uut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .day_time_stamp(dts), .pcm_valid, .pcm_in, .pcm_ready,
    .out_valid, .out_byte, .out_ready);
  rec_sink snk (.hclk, .hresetn, .slow, .out_valid, .out_byte, .out_ready);

  always #20 hclk = ~hclk;

  function automatic logic [15:0] pw(input int i);
    return 16'ha5c3 + 16'(i) * 16'h0111;
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, x);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (!hreadyout);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    r = hrdata;
  endtask

  // a stray word without frame start goes first and must be dropped
  task automatic send(input int n);
    for (int i = -1; i < n; i++) begin
      pcm_valid <= 1'b1;
      pcm_in <= '{i == 0, pw(i)};
      do @(posedge hclk); while (!pcm_ready);
    end
    pcm_valid <= 1'b0;
  endtask

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(40 * 20000);
    failures++;
    end_of_test;
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    pcm_valid = 1'b0;
    pcm_in = '0;
    slow = 1'b0;
    failures = 0;
    checks_done = 0;
    dts = '{11'h6d5, 27'd86399999, 10'd999};
    stamp = {2'b00, dts.day[8:0], dts.msec, dts.usec};
    repeat (20) @(posedge hclk);
    chk(hreadyout, 1);
    chk(out_valid, 0);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int k = 0; k < ST_WORDS; k++) begin
      for (int j = 0; j < 4; j++)
        v[8*j +: 8] = 8'(4 * k + j) ^ 8'h5a;
      bus(1'b1, 32'(OFS_STBLK) + 32'(4 * k), v, v);
    end
    chk(pcm_ready, 32'h1);
    for (int r = 0; r < 4; r++) begin
      slow <= r[0];
      bus(1'b1, 32'(OFS_WORDS), 32'(rows[r].words), v);
      bus(1'b1, 32'(OFS_CTRL), rows[r].ctrl, v);
      e = '{8'h30, 8'h03, 8'h03, 8'h30, rows[r].src, rows[r].typ,
            rows[r].off[7:0], rows[r].off[15:8]};
      if (rows[r].ctrl[CTRL_TS])
        for (int i = 5; i >= 0; i--) e.push_back(stamp[8*i +: 8]);
      if (rows[r].ctrl[CTRL_ST])
        for (int i = 0; i < 48; i++) e.push_back(8'(i) ^ 8'h5a);
      for (int i = 0; i < rows[r].words; i++) begin
        if (rows[r].ctrl[CTRL_WIDE]) e.push_back(8'(pw(i) >> 8));
        e.push_back(8'(pw(i)));
      end
      send(rows[r].words);
      while (!(snk.q.size() > 0 && snk.q[$].last)) @(posedge hclk);
      chk(snk.q.size(), e.size());
      chk(snk.q[0].first, 1);
      foreach (e[i])
        chk(snk.q[i].data, e[i]);
      snk.q.delete();
    end
    bus(1'b0, 32'(OFS_STATUS), 32'h0, v);
    chk(v, 32'h0004_0000);
    chk(hresp, 32'h0);
    bus(1'b0, 32'(OFS_CTRL), 32'h0, v);
    chk(v, 32'h0000_000f);
    bus(1'b0, 32'(OFS_STBLK), 32'h0, v);
    chk(v, 32'h0);
    bus(1'b1, 32'h0000_0100, 32'hffff_ffff, v);
    bus(1'b0, 32'h0000_0100, 32'h0, v);
    chk(v, 32'h0);
    end_of_test;
  end
endmodule
